//--- src/pst_top.sv
// Power-on self-test sequencer with APB registers and lamp drivers
`timescale 1ns/1ps
module pst_top
  import pst_pkg::*;
#(
  parameter int BLINK_CYC = pst_pkg::BLINK_HALF_CYC,
  parameter int TIMEOUT_CYC = pst_pkg::CHECK_TIMEOUT_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  // Board check hardware
  output logic CHECK_START_O,
  output logic [pst_pkg::IDX_W-1:0] CHECK_SEL_O,
  input wire logic CHECK_DONE_I,
  input wire logic CHECK_FAIL_I,
  input wire logic BOOT_FAIL_I,
  // Main memory write port
  output logic MEM_WR_O,
  output logic [23:0] MEM_ADDR_O,
  output logic [7:0] MEM_DATA_O,
  input wire logic MEM_ACK_I,
  // Front lamps
  output logic [pst_pkg::NUM_LAMPS-1:0] PROGRESS_LAMPS_O,
  output logic RESULT_LAMP_O
);
  import pst_pkg::*;

  pst_state_t state;
  pst_state_t next_state;
  logic [IDX_W-1:0] idx;
  logic [7:0] result_code;
  logic [31:0] tmo;
  logic boot_meta;
  logic boot_fail_s;
  logic boot_prev;
  logic blink;
  logic running;
  logic check_bad;
  logic last_check;
  logic restart;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;

  // Flash phase shared by both lamp groups
  pst_blinker #(
    .HALF_CYC(BLINK_CYC)
  ) u_blink (
    .clk_i(REF_CLK_I),
    .reset_i(RESET_I),
    .phase_o(blink)
  );

  // Boot failure pin passes two flip-flops
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      boot_meta <= 1'b0;
      boot_fail_s <= 1'b0;
      boot_prev <= 1'b0;
    end
    else
    begin
      boot_meta <= BOOT_FAIL_I;
      boot_fail_s <= boot_meta;
      boot_prev <= boot_fail_s;
    end
  end

  // Sequence decodes
  assign running = (state == S_START) || (state == S_REQ) ||
                   (state == S_WAIT) || (state == S_MEMWR);
  assign last_check = (idx == IDX_W'(NUM_CHECKS - 1));
  assign check_bad = (CHECK_DONE_I && CHECK_FAIL_I) ||
                     (!CHECK_DONE_I && tmo == 32'(TIMEOUT_CYC - 1));

  // Next state of the check sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      S_START: next_state = S_REQ;
      S_REQ: next_state = S_WAIT;
      S_WAIT:
      begin
        if (check_bad)
          next_state = S_MEMWR;
        else if (CHECK_DONE_I)
          next_state = last_check ? S_PASS : S_REQ;
      end
      S_MEMWR:
      begin
        if (MEM_ACK_I)
          next_state = S_FAIL;
      end
      S_PASS: next_state = restart ? S_START : S_PASS;
      S_FAIL: next_state = restart ? S_START : S_FAIL;
      default: next_state = S_START;
    endcase
  end

  // State register; reset release enters the sequence directly
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      state <= S_START;
    else
      state <= next_state;
  end

  // Check index steps through the fixed order of checks
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      idx <= '0;
    else if (state == S_START)
      idx <= '0;
    else if (state == S_WAIT && CHECK_DONE_I && !check_bad && !last_check)
      idx <= idx + IDX_W'(1);
  end

  // Watchdog on each check, a hung check counts as failed
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      tmo <= 32'h0;
    else if (state == S_WAIT)
      tmo <= tmo + 32'h1;
    else
      tmo <= 32'h0;
  end

  // Result code: cleared on each run, latched on the first failure
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      result_code <= CODE_NONE;
    else if (state == S_START)
      result_code <= CODE_NONE;
    else if (state == S_WAIT && check_bad)
      result_code <= pst_code_of(idx);
  end

  // Request to the check hardware and code byte to main memory
  assign CHECK_START_O = (state == S_REQ);
  assign CHECK_SEL_O = idx;
  assign MEM_WR_O = (state == S_MEMWR);
  assign MEM_ADDR_O = RESULT_ADDR;
  assign MEM_DATA_O = result_code;

  // Progress lamps flash only while the sequence runs
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      PROGRESS_LAMPS_O <= '0;
    else if (running)
      PROGRESS_LAMPS_O <= {NUM_LAMPS{blink}};
    else
      PROGRESS_LAMPS_O <= '0;
  end

  // Result lamp: steady on boot failure, flashing on check failure
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      RESULT_LAMP_O <= 1'b0;
    else if (boot_fail_s)
      RESULT_LAMP_O <= 1'b1;
    else if (state == S_FAIL)
      RESULT_LAMP_O <= blink;
    else
      RESULT_LAMP_O <= 1'b0;
  end

  // APB decode, zero wait states
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign apb_rd = PSEL_I && PENABLE_I && !PWRITE_I;
  assign addr_ok = (PADDR_I == OFS_CTRL) || (PADDR_I == OFS_STATUS) ||
                   (PADDR_I == OFS_RESULT) || (PADDR_I == OFS_IRQ_STAT) ||
                   (PADDR_I == OFS_IRQ_MASK);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
  assign restart = apb_wr && (PADDR_I == OFS_CTRL) && PWDATA_I[CTRL_RESTART];

  // Interrupt events and write-one-to-clear; a set beats a clear
  assign irq_set[IRQ_DONE] = running && (next_state == S_PASS || next_state == S_FAIL);
  assign irq_set[IRQ_FAIL] = (state == S_WAIT) && check_bad;
  assign irq_set[IRQ_BOOT] = boot_fail_s && !boot_prev;
  assign irq_clr = (apb_wr && PADDR_I == OFS_IRQ_STAT) ? PWDATA_I[IRQ_W-1:0] : '0;

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
  end

  // Interrupt mask
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      irq_mask <= IRQ_MASK_RST;
    else if (apb_wr && PADDR_I == OFS_IRQ_MASK)
      irq_mask <= PWDATA_I[IRQ_W-1:0];
  end

  assign IRQ_O = |(irq_stat & irq_mask);

  // Read data register, captured in the setup cycle
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      PRDATA_O <= 32'h0;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I)
    begin
      PRDATA_O <= 32'h0;
      case (PADDR_I)
        OFS_STATUS:
        begin
          PRDATA_O[ST_RUNNING] <= running;
          PRDATA_O[ST_PASSED] <= (state == S_PASS);
          PRDATA_O[ST_FAILED] <= (state == S_FAIL);
          PRDATA_O[ST_BOOTFAIL] <= boot_fail_s;
          PRDATA_O[ST_IDX_LSB +: IDX_W] <= idx;
        end
        OFS_RESULT: PRDATA_O[7:0] <= result_code;
        OFS_IRQ_STAT: PRDATA_O[IRQ_W-1:0] <= irq_stat;
        OFS_IRQ_MASK: PRDATA_O[IRQ_W-1:0] <= irq_mask;
        default: PRDATA_O <= 32'h0;
      endcase
    end
  end

  // Checks on the sequencer behaviour
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  a_start_on_reset: assert property (
    $past(RESET_I) && !RESET_I |-> state == S_START ##1 state == S_REQ)
    else $error("sequence did not start after reset");

  a_lamps_flash: assert property (
    running && $past(running) |=> PROGRESS_LAMPS_O == {NUM_LAMPS{$past(blink)}})
    else $error("progress lamps not flashing while running");

  a_lamps_off_done: assert property (
    (state == S_PASS || state == S_FAIL) |=> PROGRESS_LAMPS_O == '0)
    else $error("progress lamps on after sequence end");

  a_pass_lamp_off: assert property (
    state == S_PASS && !boot_fail_s |=> !RESULT_LAMP_O)
    else $error("result lamp on after passing run");

  a_fail_mem_write: assert property (
    state == S_WAIT && check_bad |=> MEM_WR_O && MEM_ADDR_O == RESULT_ADDR
      && MEM_DATA_O == pst_code_of(idx))
    else $error("failure code not written to result address");

  a_fail_lamp_flash: assert property (
    state == S_FAIL && !boot_fail_s |=> RESULT_LAMP_O == $past(blink))
    else $error("result lamp not flashing after failure");

  a_code_table: assert property (
    state == S_WAIT && check_bad && idx == 4'h3 |=> MEM_DATA_O == 8'hA4)
    else $error("wrong code for fourth check");

  a_result_held: assert property (
    state == S_FAIL && !restart |=> state == S_FAIL && $stable(result_code))
    else $error("stored result changed before restart");

  a_boot_steady: assert property (
    boot_fail_s [*2] |=> RESULT_LAMP_O && $past(RESULT_LAMP_O))
    else $error("result lamp not steady on boot failure");

  a_irq_sticky: assert property (
    irq_set[IRQ_FAIL] |=> irq_stat[IRQ_FAIL])
    else $error("failure event lost");

  a_check_timeout: assert property (
    state == S_WAIT && !CHECK_DONE_I && tmo == 32'(TIMEOUT_CYC - 1) |=> state == S_MEMWR)
    else $error("hung check not treated as failed");

  a_mem_hold: assert property (
    MEM_WR_O && !MEM_ACK_I |=> MEM_WR_O && $stable(MEM_DATA_O))
    else $error("memory write dropped before acknowledge");

  a_one_write: assert property (
    MEM_WR_O && MEM_ACK_I |=> !MEM_WR_O)
    else $error("memory write repeated after acknowledge");

  a_pass_at_end: assert property (
    state == S_WAIT && CHECK_DONE_I && !check_bad && last_check |=> state == S_PASS)
    else $error("sequence did not pass after last check");

  a_code_cleared: assert property (
    state == S_START |=> result_code == CODE_NONE)
    else $error("result code not cleared at sequence start");

  a_sel_stable: assert property (
    state == S_WAIT && !CHECK_DONE_I |=> $stable(CHECK_SEL_O))
    else $error("check select moved during a check");

  a_restart_go: assert property (
    (state == S_PASS || state == S_FAIL) && restart |=> state == S_START)
    else $error("restart command not honoured");

  a_boot_event: assert property (
    boot_fail_s && !boot_prev |=> irq_stat[IRQ_BOOT])
    else $error("boot failure event lost");

  a_event_clear: assert property (
    irq_clr[IRQ_DONE] && !irq_set[IRQ_DONE] |=> !irq_stat[IRQ_DONE])
    else $error("done event not cleared by write of one");
endmodule

//--- pkg/pst_pkg.sv
// Constants, types and code table for the power-on self-test sequencer
// Operation
// - Reset release starts the self-test sequence
// - Progress lamps flash while running, then off
// - All checks pass: result lamp off
// - Failure: result lamp flashes, code written to 0xF0
// - Codes 00 none, A0 core, A1 ROM
// - Codes A3 control register, A4 DMA registers
// - Codes A5 DMA interrupt, A8/A9 timer
// - Codes AA memory protection, AD main memory
// - Codes B4 real-time clock, B6 EEPROM
// - Codes BB floppy, BC SCSI, BD serial bus
// - Result kept in battery-backed memory until the next failure
package pst_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int CHECK_TIMEOUT_US = 100;
  localparam int CHECK_TIMEOUT_CYC = CHECK_TIMEOUT_US * CLK_MHZ;
  // Check sequence
  localparam int NUM_CHECKS = 14;
  localparam int IDX_W = 4;
  localparam int NUM_LAMPS = 8;
  localparam logic [23:0] RESULT_ADDR = 24'h0000F0;
  // Result codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_CORE = 8'hA0;
  localparam logic [7:0] CODE_ROM = 8'hA1;
  localparam logic [7:0] CODE_CTRL = 8'hA3;
  localparam logic [7:0] CODE_DMA_REG = 8'hA4;
  localparam logic [7:0] CODE_DMA_INT = 8'hA5;
  localparam logic [7:0] CODE_TMR_REG = 8'hA8;
  localparam logic [7:0] CODE_TMR_INT = 8'hA9;
  localparam logic [7:0] CODE_MPROT = 8'hAA;
  localparam logic [7:0] CODE_MEM = 8'hAD;
  localparam logic [7:0] CODE_RTC = 8'hB4;
  localparam logic [7:0] CODE_EEPROM = 8'hB6;
  localparam logic [7:0] CODE_FDC = 8'hBB;
  localparam logic [7:0] CODE_SCSI = 8'hBC;
  localparam logic [7:0] CODE_SBUS = 8'hBD;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // Field positions
  localparam int CTRL_RESTART = 0;
  localparam int ST_RUNNING = 0;
  localparam int ST_PASSED = 1;
  localparam int ST_FAILED = 2;
  localparam int ST_BOOTFAIL = 3;
  localparam int ST_IDX_LSB = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_BOOT = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    S_START = 6'h01,
    S_REQ = 6'h02,
    S_WAIT = 6'h04,
    S_MEMWR = 6'h08,
    S_PASS = 6'h10,
    S_FAIL = 6'h20
  } pst_state_t;

  // Result code of the check at a given position in the sequence
  function automatic logic [7:0] pst_code_of(input logic [IDX_W-1:0] idx);
    case (idx)
      4'h0: pst_code_of = CODE_CORE;
      4'h1: pst_code_of = CODE_ROM;
      4'h2: pst_code_of = CODE_CTRL;
      4'h3: pst_code_of = CODE_DMA_REG;
      4'h4: pst_code_of = CODE_DMA_INT;
      4'h5: pst_code_of = CODE_TMR_REG;
      4'h6: pst_code_of = CODE_TMR_INT;
      4'h7: pst_code_of = CODE_MPROT;
      4'h8: pst_code_of = CODE_MEM;
      4'h9: pst_code_of = CODE_RTC;
      4'hA: pst_code_of = CODE_EEPROM;
      4'hB: pst_code_of = CODE_FDC;
      4'hC: pst_code_of = CODE_SCSI;
      4'hD: pst_code_of = CODE_SBUS;
      default: pst_code_of = CODE_NONE;
    endcase
  endfunction
endpackage

//--- src/pst_blinker.sv
// Free-running flash phase generator for the status lamps
`timescale 1ns/1ps
module pst_blinker #(
  parameter int HALF_CYC = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  output logic phase_o
);
  logic [31:0] cnt;

  // Toggle the phase every half period
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt <= 32'h0;
      phase_o <= 1'b0;
    end
    else if (cnt == 32'(HALF_CYC - 1))
    begin
      cnt <= 32'h0;
      phase_o <= ~phase_o;
    end
    else
    begin
      cnt <= cnt + 32'h1;
    end
  end

  // Phase only changes at the end of a half period
  a_blink_period: assert property (@(posedge clk_i) disable iff (reset_i)
    (cnt != 32'(HALF_CYC - 1)) |=> $stable(phase_o))
    else $error("flash phase changed early");
endmodule

//--- dv/pst_far_model.sv
// Far-side model: board check hardware and battery-backed main memory
`timescale 1ns/1ps
module pst_far_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [3:0] sel_i,
  input wire logic [3:0] fail_idx_i,
  input wire logic [1:0] delay_i,
  input wire logic mute_i,
  input wire logic wr_i,
  input wire logic [23:0] addr_i,
  input wire logic [7:0] data_i,
  output logic done_o,
  output logic fail_o,
  output logic ack_o,
  output logic [7:0] mem_f0_o,
  output int wr_cnt_o
);
  logic [1:0] wait_cnt = 2'h0;
  // Check answers one cycle after start; a muted failing check never answers
  always @(posedge clk_i)
  begin
    done_o <= !reset_i && start_i && !(mute_i && sel_i == fail_idx_i);
    fail_o <= start_i ? (sel_i == fail_idx_i) : !fail_o;
  end
  // Memory acknowledges after delay_i cycles; contents ignore reset
  always @(posedge clk_i)
  begin
    if (wr_i && !ack_o && wait_cnt == delay_i)
    begin
      ack_o <= 1'h1;
      wait_cnt <= 2'h0;
      wr_cnt_o <= wr_cnt_o + 1;
      if (addr_i == 24'h0000F0)
        mem_f0_o <= data_i;
    end
    else
    begin
      ack_o <= 1'h0;
      wait_cnt <= (wr_i && !ack_o) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule

//--- dv/testbench.sv
// Self-checking bench for the power-on self-test sequencer
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [3:0] idx; logic [7:0] code;} pst_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pwr = 1'h0;
  logic boot = 1'h0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [3:0] fidx = 4'hF;
  logic [1:0] dly = 2'h0;
  logic mute = 1'h0;
  logic [31:0] prd, rd;
  logic prdy, slverr, err, irq, start, done, cfail, wr, ack, rlamp, seen_on, fl;
  logic [3:0] sel;
  logic [23:0] maddr;
  logic [7:0] mdata, mem, plamps, last;
  int wcnt, n, bad_count = 0, checks = 0, cyc = 0;
  pst_row_t rows [15];
  always #2 clk = ~clk;
  pst_top #(.BLINK_CYC(4), .TIMEOUT_CYC(20)) dut (.REF_CLK_I(clk), .RESET_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(slverr), .IRQ_O(irq),
    .CHECK_START_O(start), .CHECK_SEL_O(sel), .CHECK_DONE_I(done), .CHECK_FAIL_I(cfail),
    .BOOT_FAIL_I(boot), .MEM_WR_O(wr), .MEM_ADDR_O(maddr), .MEM_DATA_O(mdata),
    .MEM_ACK_I(ack), .PROGRESS_LAMPS_O(plamps), .RESULT_LAMP_O(rlamp));
  pst_far_model far (.clk_i(clk), .reset_i(rst), .start_i(start), .sel_i(sel),
    .fail_idx_i(fidx), .delay_i(dly), .mute_i(mute), .wr_i(wr), .addr_i(maddr),
    .data_i(mdata), .done_o(done), .fail_o(cfail), .ack_o(ack), .mem_f0_o(mem),
    .wr_cnt_o(wcnt));
  // Notes any full-on flash phase of the progress lamps
  always @(posedge clk)
    if (plamps === 8'hFF)
      seen_on <= 1'h1;
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (prdy !== 1'h1)
      @(posedge clk);
    rd = prd;
    err = slverr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  // Starts a run by reset or restart command and polls until it stops
  task automatic run(input logic [3:0] f, input logic [1:0] d, input logic by_reset);
    int k;
    @(posedge clk);
    fidx <= f;
    dly <= d;
    if (by_reset)
    begin
      rst <= 1'h1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({start, wr, plamps, rlamp}, 32'h0, "reset outputs");
      @(posedge clk);
      rst <= 1'h0;
    end
    else
      apb(1'h1, 8'h00, 32'h1);
    seen_on = 1'h0;
    k = 0;
    do
    begin
      apb(1'h0, 8'h04, 32'h0);
      k++;
    end
    while (rd[0] !== 1'h0 && k < 100);
    // A run that never stops is a failure of its own
    if (rd[0] !== 1'h0)
    begin
      bad_count++;
      close_out();
    end
  endtask
  initial
  begin
    rows = '{'{4'h0, 8'hA0}, '{4'h1, 8'hA1}, '{4'h2, 8'hA3}, '{4'h3, 8'hA4},
      '{4'h4, 8'hA5}, '{4'h5, 8'hA8}, '{4'h6, 8'hA9}, '{4'h7, 8'hAA}, '{4'h8, 8'hAD},
      '{4'h9, 8'hB4}, '{4'hA, 8'hB6}, '{4'hB, 8'hBB}, '{4'hC, 8'hBC}, '{4'hD, 8'hBD},
      '{4'hF, 8'h00}};
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 15; i++)
    begin
      n = wcnt;
      run(rows[i].idx, 2'(i), 1'h1);
      fl = rows[i].code != 8'h00;
      chk(32'(wcnt - n), {31'h0, fl}, "memory writes");
      if (fl)
        last = rows[i].code;
      chk({24'h0, mem}, {24'h0, last}, "stored code");
      chk(rd & 32'hFF, fl ? {rows[i].idx, 4'h4} : 32'hD2, "status");
      apb(1'h0, 8'h08, 32'h0);
      chk(rd, {24'h0, rows[i].code}, "result code");
      apb(1'h0, 8'h0C, 32'h0);
      chk(rd, fl ? 32'h3 : 32'h1, "event bits");
      n = 0;
      repeat (12)
      begin
        @(negedge clk);
        n += (rlamp === 1'h1);
      end
      chk((n == 0) ? 32'h0 : (n == 12) ? 32'h2 : 32'h1, {31'h0, fl}, "result lamp");
      chk({24'h0, plamps}, 32'h0, "progress lamps off");
      if (rows[i].idx >= 4'h8)
        chk({31'h0, seen_on}, 32'h1, "progress flash");
      chk({31'h0, irq}, 32'h0, "masked irq");
    end
    // Interrupt mask, raise and write-one clear
    apb(1'h1, 8'h10, 32'h1);
    apb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h1, "mask readback");
    @(negedge clk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'h1, 8'h0C, 32'h7);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // Unmapped address and read-only result
    apb(1'h0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'h1, 8'h08, 32'hFF);
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h0, "result read only");
    // Restart by command with a slow memory
    run(4'h3, 2'h3, 1'h0);
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'hA4, "restart code");
    chk({24'h0, mem}, 32'hA4, "restart stored");
    // A check that never answers times out and fails
    mute <= 1'h1;
    run(4'h5, 2'h1, 1'h1);
    mute <= 1'h0;
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'hA8, "timeout code");
    chk({24'h0, mem}, 32'hA8, "timeout stored");
    // Boot failure holds the result lamp on
    boot <= 1'h1;
    repeat (6) @(posedge clk);
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      n += (rlamp === 1'h1);
    end
    chk(32'(n), 32'h8, "boot lamp steady");
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h7, "boot event");
    boot <= 1'h0;
    close_out();
  end
endmodule
